// ### hw/acc_pkg.sv
`default_nettype none
package acc_pkg;

	// ==========================================================
	// widths
	localparam int DATA_W = 8; // register width
	localparam int RES_W = 9; // conversion result width
	localparam int CHAN_W = 2; // usable channel code width
	localparam int LINES = 4; // port b lines
	localparam int IDX_W = 6; // register index width

	// ==========================================================
	// register indexes, byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_RESULT_LO = 6'h20;
	localparam logic [IDX_W-1:0] IDX_RESULT_HI = 6'h21;
	localparam logic [IDX_W-1:0] IDX_CONV_CTRL = 6'h22;
	localparam logic [IDX_W-1:0] IDX_CLK_SEL = 6'h23;
	localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 6'h24;
	localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR = 6'h25;
	localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 6'h26;
	localparam logic [IDX_W-1:0] IDX_IRQ_CTRL = 6'h27;

	// ==========================================================
	// converter control fields
	localparam int CC_CHAN_LSB = 0;
	localparam int CC_PCR_LSB = 3;
	localparam int CC_PCR_W = 3;
	localparam int CC_PEND_BIT = 6;
	localparam int CC_START_BIT = 7;
	localparam logic [DATA_W-1:0] CC_RESET = 8'h00;

	// clock select fields
	localparam int CS_DIV_LSB = 0;
	localparam int CS_DIV_W = 2;
	localparam int CS_TEST_BIT = 7;
	localparam logic [DATA_W-1:0] CS_RESET = 8'h00;
	localparam logic [CS_DIV_W-1:0] DIV_SEL_2 = 2'h0;
	localparam logic [CS_DIV_W-1:0] DIV_SEL_8 = 2'h1;
	localparam logic [CS_DIV_W-1:0] DIV_SEL_32 = 2'h2;
	localparam int DIV_CNT_W = 5;
	localparam logic [DIV_CNT_W-1:0] DIV_LAST_2 = 5'h01;
	localparam logic [DIV_CNT_W-1:0] DIV_LAST_8 = 5'h07;
	localparam logic [DIV_CNT_W-1:0] DIV_LAST_32 = 5'h1f;

	// analog line configuration codes and line masks
	localparam logic [CC_PCR_W-1:0] PCR_NONE = 3'h0;
	localparam logic [CC_PCR_W-1:0] PCR_ONE = 3'h1;
	localparam logic [CC_PCR_W-1:0] PCR_TWO = 3'h2;
	localparam logic [CC_PCR_W-1:0] PCR_THREE = 3'h3;
	localparam logic [LINES-1:0] LINES_NONE = 4'h0;
	localparam logic [LINES-1:0] LINES_ONE = 4'h1;
	localparam logic [LINES-1:0] LINES_TWO = 4'h3;
	localparam logic [LINES-1:0] LINES_THREE = 4'h7;
	localparam logic [LINES-1:0] LINES_ALL = 4'hf;

	// result byte layout
	localparam int RES_LO_BIT = 7;

	// interrupt registers
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_GLOBAL_BIT = 0;
	localparam logic [DATA_W-1:0] IRQ_RESET = 8'h00;

	// converter clocks spent sampling before the first trial
	localparam int SAMPLE_TICKS = 2;

	// ==========================================================
	// successive approximation states
	typedef enum logic [2:0] {
		SAR_IDLE = 3'h1,
		SAR_SAMPLE = 3'h2,
		SAR_CONV = 3'h4
	} acc_sar_state_t;

endpackage
`default_nettype wire

// ### hw/acc_conv_if.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// link between the control logic and the approximation engine
interface acc_conv_if #(parameter int RES_W = 9);
	logic tick; // one-cycle converter clock strobe
	logic abort; // drop any conversion in progress
	logic go; // begin a conversion
	logic cmp; // comparator: input at or above trial code
	logic busy; // engine is sampling or converting
	logic done; // one-cycle pulse, result valid
	logic [RES_W-1:0] result; // last finished code
	logic [RES_W-1:0] dac; // trial code for the comparator
	modport ctrl (output tick, abort, go, cmp,
		input busy, done, result, dac);
	modport sar (input tick, abort, go, cmp,
		output busy, done, result, dac);
endinterface
`default_nettype wire

// ### hw/acc_sar.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// successive approximation engine, one bit per converter clock
module acc_sar #(
	parameter int RES_W = 9,
	parameter int SAMPLE_TICKS = acc_pkg::SAMPLE_TICKS
) (
	input wire logic clk_i,
	input wire logic rst_i,
	acc_conv_if.sar cv
);
	localparam logic [RES_W-1:0] LSB_ONE = {{(RES_W-1){1'b0}}, 1'b1};
	localparam logic [3:0] TOP_BIT = 4'(RES_W-1);
	localparam logic [3:0] SMP_LAST = 4'(SAMPLE_TICKS-1);

	acc_pkg::acc_sar_state_t state; // engine state
	logic [3:0] smp_cnt; // sampling clocks seen
	logic [3:0] bit_idx; // bit under trial
	logic [RES_W-1:0] bit_mask; // one-hot of bit under trial
	logic [RES_W-1:0] next_code; // trial code after decision

	assign bit_mask = LSB_ONE << bit_idx;
	// keep the trial bit only if the input reached it
	assign next_code = cv.cmp ? cv.dac : (cv.dac & ~bit_mask);
	assign cv.busy = (state != acc_pkg::SAR_IDLE);

	// ==========================================================
	// state sequence; abort always wins so a restart is clean
	always_ff @(posedge clk_i) begin
		if (rst_i || cv.abort) begin
			state <= acc_pkg::SAR_IDLE;
		end else begin
			unique case (state)
				acc_pkg::SAR_IDLE: begin
					if (cv.go) begin
						state <= acc_pkg::SAR_SAMPLE;
					end
				end
				acc_pkg::SAR_SAMPLE: begin
					if (cv.tick && smp_cnt == SMP_LAST) begin
						state <= acc_pkg::SAR_CONV;
					end
				end
				acc_pkg::SAR_CONV: begin
					if (cv.tick && bit_idx == 4'h0) begin
						state <= acc_pkg::SAR_IDLE;
					end
				end
			endcase
		end
	end

	// sampling counter
	always_ff @(posedge clk_i) begin
		if (rst_i || state != acc_pkg::SAR_SAMPLE) begin
			smp_cnt <= 4'h0;
		end else if (cv.tick) begin
			smp_cnt <= smp_cnt + 4'h1;
		end
	end

	// ==========================================================
	// trial code and bit pointer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cv.dac <= '0;
			bit_idx <= 4'h0;
		end else if (state == acc_pkg::SAR_IDLE && cv.go) begin
			cv.dac <= LSB_ONE << TOP_BIT;
			bit_idx <= TOP_BIT;
		end else if (state == acc_pkg::SAR_CONV && cv.tick) begin
			if (bit_idx != 4'h0) begin
				cv.dac <= next_code | (bit_mask >> 1);
				bit_idx <= bit_idx - 4'h1;
			end else begin
				cv.dac <= next_code;
			end
		end
	end

	// finished code and its strobe
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cv.result <= '0;
			cv.done <= 1'b0;
		end else begin
			cv.done <= !cv.abort && state == acc_pkg::SAR_CONV &&
				cv.tick && bit_idx == 4'h0;
			if (!cv.abort && state == acc_pkg::SAR_CONV &&
				cv.tick && bit_idx == 4'h0) begin
				cv.result <= next_code;
			end
		end
	end
endmodule
`default_nettype wire

// ### hw/acc_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// converter clock and conversion control, wishbone slave
module acc_ctrl #(
	parameter int ADDR_W = 8,
	parameter int SAMPLE_TICKS = acc_pkg::SAMPLE_TICKS
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// analog side
	input wire logic cmp_i,
	output logic [acc_pkg::RES_W-1:0] dac_code_o,
	output logic [acc_pkg::CHAN_W-1:0] chan_sel_o,
	output logic [acc_pkg::LINES-1:0] analog_en_o,
	output logic adc_power_o,
	output logic adc_busy_o,
	// interrupt
	output logic irq_o
);

	// ==========================================================
	// internal wires
	acc_conv_if #(.RES_W(acc_pkg::RES_W)) cv ();

	logic req; // fresh request this cycle
	logic wr; // write to the low byte lane
	logic [acc_pkg::IDX_W-1:0] idx; // word index of request
	logic [7:0] wdat; // low byte of write data
	logic wr_cc; // write to converter control
	logic wr_cs; // write to clock select
	logic start_rise; // start bit written 0 to 1
	logic start_fall; // start bit written 1 to 0
	logic pcr_change; // analog configuration altered
	logic [acc_pkg::CC_PCR_W-1:0] new_pcr; // written config
	logic [acc_pkg::DIV_CNT_W-1:0] div_last; // divider end count
	logic [acc_pkg::DATA_W-1:0] rd_data; // read mux output

	// ==========================================================
	// registers
	logic [acc_pkg::CS_DIV_W-1:0] clk_div_sel; // clock select
	logic test_bit; // factory test bit, no function
	logic [2:0] channel_select_field; // channel code
	logic [acc_pkg::CC_PCR_W-1:0] portb_analog_config_field;
	logic conversion_pending_flag; // high while converting
	logic start_bit; // last written start level
	logic [acc_pkg::RES_W-1:0] result; // held result
	logic converter_irq_flag; // sticky completion event
	logic converter_irq_enable; // per-event enable
	logic global_irq_enable; // master enable
	logic [acc_pkg::DIV_CNT_W-1:0] div_cnt; // divider count
	logic tick; // converter clock strobe
	logic go; // conversion launch pulse
	logic abort; // conversion abort pulse

	// ==========================================================
	// bus decode
	// only the cycle before ack counts, so a held request
	// is taken exactly once
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = req && wb_we_i && wb_sel_i[0];
	assign idx = wb_adr_i[acc_pkg::IDX_W+1:2];
	assign wdat = wb_dat_i[7:0];
	assign wr_cc = wr && idx == acc_pkg::IDX_CONV_CTRL;
	assign wr_cs = wr && idx == acc_pkg::IDX_CLK_SEL;
	assign new_pcr = wdat[acc_pkg::CC_PCR_LSB +:
		acc_pkg::CC_PCR_W];

	// start edges are seen from the written value against
	// the stored one; a rewrite of the same level is no edge
	assign start_rise = wr_cc && wdat[acc_pkg::CC_START_BIT] &&
		!start_bit;
	assign start_fall = wr_cc && !wdat[acc_pkg::CC_START_BIT] &&
		start_bit;
	assign pcr_change = wr_cc &&
		new_pcr != portb_analog_config_field;

	// ack one cycle after the request, dropped the next cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end

	// ==========================================================
	// clock select register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clk_div_sel <= acc_pkg::CS_RESET[acc_pkg::CS_DIV_LSB +:
				acc_pkg::CS_DIV_W];
			test_bit <= acc_pkg::CS_RESET[acc_pkg::CS_TEST_BIT];
		end else if (wr_cs) begin
			clk_div_sel <= wdat[acc_pkg::CS_DIV_LSB +:
				acc_pkg::CS_DIV_W];
			// stored only so software reads back its value
			test_bit <= wdat[acc_pkg::CS_TEST_BIT];
		end
	end

	// ==========================================================
	// converter clock divider
	// the undefined code runs as the slowest clock, the
	// safest choice for an analog stage
	always_comb begin
		unique case (clk_div_sel)
			acc_pkg::DIV_SEL_2: div_last = acc_pkg::DIV_LAST_2;
			acc_pkg::DIV_SEL_8: div_last = acc_pkg::DIV_LAST_8;
			default: div_last = acc_pkg::DIV_LAST_32;
		endcase
	end

	// free running counter; a select change takes effect at
	// the latest after one full slow period
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_cnt <= '0;
			tick <= 1'b0;
		end else if (div_cnt >= div_last) begin
			div_cnt <= '0;
			tick <= 1'b1;
		end else begin
			div_cnt <= div_cnt + 5'h01;
			tick <= 1'b0;
		end
	end

	// ==========================================================
	// converter control fields
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			channel_select_field <= acc_pkg::CC_RESET[
				acc_pkg::CC_CHAN_LSB +: 3];
			portb_analog_config_field <= acc_pkg::CC_RESET[
				acc_pkg::CC_PCR_LSB +: acc_pkg::CC_PCR_W];
			start_bit <= acc_pkg::CC_RESET[acc_pkg::CC_START_BIT];
		end else if (wr_cc) begin
			// 0x20 lands here as all lines analog, channel 0
			channel_select_field <= wdat[
				acc_pkg::CC_CHAN_LSB +: 3];
			portb_analog_config_field <= new_pcr;
			start_bit <= wdat[acc_pkg::CC_START_BIT];
		end
	end

	// pending flag: the start rise sets it and wins over a
	// completion in the same cycle, completion clears it;
	// a write never touches it directly
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			conversion_pending_flag <=
				acc_pkg::CC_RESET[acc_pkg::CC_PEND_BIT];
		end else if (start_rise) begin
			conversion_pending_flag <= 1'b1;
		end else if (cv.done) begin
			conversion_pending_flag <= 1'b0;
		end
	end

	// ==========================================================
	// conversion launch and abort
	// with no analog line the converter is unpowered and a
	// falling start is ignored; the flag then stays high
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			go <= 1'b0;
			abort <= 1'b0;
		end else begin
			go <= start_fall &&
				portb_analog_config_field != acc_pkg::PCR_NONE;
			// a reconfiguration also drops a running conversion
			// so no half result is ever published
			abort <= start_rise || pcr_change;
		end
	end

	assign cv.tick = tick;
	assign cv.go = go;
	assign cv.abort = abort;
	assign cv.cmp = cmp_i;

	acc_sar #(
		.RES_W(acc_pkg::RES_W),
		.SAMPLE_TICKS(SAMPLE_TICKS)
	) u_sar (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cv(cv)
	);

	// ==========================================================
	// result holding
	// only a completion writes it, so high and low bytes read
	// with no completion between them belong to the same conversion
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			result <= '0;
		end else if (cv.done) begin
			result <= cv.result;
		end
	end

	// ==========================================================
	// interrupt status, enable and master enable
	// set wins over a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			converter_irq_flag <= acc_pkg::IRQ_RESET[
				acc_pkg::IRQ_DONE_BIT];
		end else if (cv.done) begin
			converter_irq_flag <= 1'b1;
		end else if (wr && idx == acc_pkg::IDX_IRQ_CLEAR &&
			wdat[acc_pkg::IRQ_DONE_BIT]) begin
			converter_irq_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			converter_irq_enable <= acc_pkg::IRQ_RESET[
				acc_pkg::IRQ_DONE_BIT];
			global_irq_enable <= acc_pkg::IRQ_RESET[
				acc_pkg::IRQ_GLOBAL_BIT];
		end else if (wr && idx == acc_pkg::IDX_IRQ_ENABLE) begin
			converter_irq_enable <= wdat[acc_pkg::IRQ_DONE_BIT];
		end else if (wr && idx == acc_pkg::IDX_IRQ_CTRL) begin
			global_irq_enable <= wdat[acc_pkg::IRQ_GLOBAL_BIT];
		end
	end

	// level request, one cycle behind the flag
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= converter_irq_flag && converter_irq_enable &&
				global_irq_enable;
		end
	end

	// ==========================================================
	// read mux; clear register and unmapped words read zero
	always_comb begin
		rd_data = '0;
		unique case (idx)
			acc_pkg::IDX_RESULT_LO: begin
				rd_data[acc_pkg::RES_LO_BIT] = result[0];
			end
			acc_pkg::IDX_RESULT_HI: begin
				rd_data = result[acc_pkg::RES_W-1:1];
			end
			acc_pkg::IDX_CONV_CTRL: begin
				rd_data[acc_pkg::CC_CHAN_LSB +: 3] =
					channel_select_field;
				rd_data[acc_pkg::CC_PCR_LSB +: acc_pkg::CC_PCR_W] =
					portb_analog_config_field;
				rd_data[acc_pkg::CC_PEND_BIT] =
					conversion_pending_flag;
				rd_data[acc_pkg::CC_START_BIT] = start_bit;
			end
			acc_pkg::IDX_CLK_SEL: begin
				// bits two to six stay zero
				rd_data[acc_pkg::CS_DIV_LSB +: acc_pkg::CS_DIV_W] =
					clk_div_sel;
				rd_data[acc_pkg::CS_TEST_BIT] = test_bit;
			end
			acc_pkg::IDX_IRQ_STATUS: begin
				rd_data[acc_pkg::IRQ_DONE_BIT] = converter_irq_flag;
			end
			acc_pkg::IDX_IRQ_ENABLE: begin
				rd_data[acc_pkg::IRQ_DONE_BIT] = converter_irq_enable;
			end
			acc_pkg::IDX_IRQ_CTRL: begin
				rd_data[acc_pkg::IRQ_GLOBAL_BIT] = global_irq_enable;
			end
			default: begin
				rd_data = '0;
			end
		endcase
	end

	// read data latched with ack, zero otherwise
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= '0;
		end else if (req && !wb_we_i) begin
			wb_dat_o <= {24'h000000, rd_data};
		end else begin
			wb_dat_o <= '0;
		end
	end

	// ==========================================================
	// analog side outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			analog_en_o <= acc_pkg::LINES_NONE;
			adc_power_o <= 1'b0;
			chan_sel_o <= '0;
		end else begin
			// channel codes with the top bit set are unusable;
			// only the low two bits reach the multiplexer
			chan_sel_o <= channel_select_field[
				acc_pkg::CHAN_W-1:0];
			adc_power_o <= portb_analog_config_field !=
				acc_pkg::PCR_NONE;
			unique case (portb_analog_config_field)
				acc_pkg::PCR_NONE: analog_en_o <= acc_pkg::LINES_NONE;
				acc_pkg::PCR_ONE: analog_en_o <= acc_pkg::LINES_ONE;
				acc_pkg::PCR_TWO: analog_en_o <= acc_pkg::LINES_TWO;
				acc_pkg::PCR_THREE:
					analog_en_o <= acc_pkg::LINES_THREE;
				default: analog_en_o <= acc_pkg::LINES_ALL;
			endcase
		end
	end

	// trial code and busy, mirrored from the engine
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			adc_busy_o <= 1'b0;
		end else begin
			adc_busy_o <= cv.busy;
		end
	end

	assign dac_code_o = cv.dac;

endmodule
`default_nettype wire

// ### verif/acc_ctrl_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// port checker for the converter clock and control block
module acc_ctrl_monitor #(
	parameter int ADDR_W = 8,
	parameter int SAMPLE_TICKS = 2
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic cmp_i,
	input wire logic [acc_pkg::RES_W-1:0] dac_code_o,
	input wire logic [acc_pkg::CHAN_W-1:0] chan_sel_o,
	input wire logic [acc_pkg::LINES-1:0] analog_en_o,
	input wire logic adc_power_o,
	input wire logic adc_busy_o,
	input wire logic irq_o
);
	// longest conversion: eleven ticks of divide 32 plus slack
	localparam int BUSY_MAX = 400;
	logic [9:0] busy_cnt; // cycles spent busy so far
	wire logic [5:0] idx = wb_adr_i[7:2]; // register index
	wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o; // taken edge
	wire logic ctrl_wr = take && wb_we_i && wb_sel_i[0]
		&& idx == acc_pkg::IDX_CONV_CTRL; // control write
	wire logic sel_rd = take && !wb_we_i && idx == acc_pkg::IDX_CLK_SEL;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ============================================================
	// busy span counter, so a hung engine shows up as a bound
	always_ff @(posedge clk_i) begin
		if (rst_i || !adc_busy_o) begin
			busy_cnt <= 10'h000;
		end else begin
			busy_cnt <= busy_cnt + 10'h001;
		end
	end

	// ============================================================
	// bus handshake
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_ack_answer: assert property (take |=> wb_ack_o)
		else $error("request not acknowledged next cycle");
	a_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack cycle");
	// ============================================================
	// register and pin relations
	a_clksel_zero: assert property ($past(sel_rd) && wb_ack_o |-> wb_dat_o[6:2] == 5'h00)
		else $error("clock select unused bits not zero");
	a_power_lines: assert property (adc_power_o == (analog_en_o != 4'h0))
		else $error("power does not match analog lines");
	// field lands at the taking edge, the pin one edge later
	a_cfg_none: assert property (ctrl_wr && wb_dat_i[5:3] == 3'h0
		|-> ##2 analog_en_o == 4'h0)
		else $error("config zero left lines analog");
	a_cfg_all: assert property (ctrl_wr && wb_dat_i[5]
		|-> ##2 analog_en_o == 4'hf)
		else $error("config with top bit not all analog");
	a_chan_sel: assert property (ctrl_wr
		|-> ##2 chan_sel_o == $past(wb_dat_i[1:0], 2))
		else $error("channel select not taken");
	a_busy_power: assert property ($rose(adc_busy_o) |-> adc_power_o)
		else $error("conversion began while powered off");
	a_busy_bound: assert property (busy_cnt < BUSY_MAX)
		else $error("conversion did not end in time");
	// main scenarios
	c_conv_end: cover property ($fell(adc_busy_o));
	c_irq_rise: cover property ($rose(irq_o));
	c_cfg_all: cover property (ctrl_wr && wb_dat_i[5]);
endmodule
bind acc_ctrl acc_ctrl_monitor #(.ADDR_W(ADDR_W), .SAMPLE_TICKS(SAMPLE_TICKS))
	acc_ctrl_monitor_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .cmp_i(cmp_i), .dac_code_o(dac_code_o),
	.chan_sel_o(chan_sel_o), .analog_en_o(analog_en_o),
	.adc_power_o(adc_power_o), .adc_busy_o(adc_busy_o), .irq_o(irq_o));
`default_nettype wire

// ### verif/adc_clock_and_conversion_control_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// register level bench for the converter control block
module adc_clock_and_conversion_control_tb_top;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, cmp_i;
	logic [7:0] wb_adr_i; // byte address
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic wb_ack_o, adc_power_o, adc_busy_o, irq_o;
	logic [8:0] dac_code_o;
	logic [1:0] chan_sel_o;
	logic [3:0] analog_en_o;
	logic [8:0] tgt; // analog level, as a code
	logic [7:0] q; // last read byte
	int num_errors, n_checks;
	logic [3:0] lines_exp [8] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hf, 4'hf, 4'hf, 4'hf};
	logic [8:0] tgts [3] = '{9'h1ff, 9'h000, 9'h155};

	acc_ctrl acc_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .cmp_i(cmp_i), .dac_code_o(dac_code_o),
		.chan_sel_o(chan_sel_o), .analog_en_o(analog_en_o),
		.adc_power_o(adc_power_o), .adc_busy_o(adc_busy_o), .irq_o(irq_o));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// comparator stand-in: input at or above the trial code
	always @(posedge clk_i) begin
		cmp_i <= (dac_code_o <= tgt);
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("checks %0d, mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// one classic cycle; entered just after a rising edge
	task automatic bus(input logic we, input logic [5:0] idx, input logic [7:0] d,
		input logic [3:0] sel, output logic [7:0] rd);
		int n;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {idx, 2'b00};
		wb_sel_i <= sel;
		wb_dat_i <= {24'h0, d};
		n = 0;
		// no bound here: a silent slave is left to the watchdog
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1);
		// taken at the first edge, ack seen at the second
		chk("bus ack latency", n, 32'h2);
		rd = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d, 4'hf, q);
	endtask
	task automatic rdc(input string what, input logic [5:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00, 4'hf, q);
		chk(what, {24'h0, q}, {24'h0, exp});
	endtask
	// full start sequence, then poll the pending flag
	task automatic conv(input logic [1:0] div, input logic [8:0] t);
		int n;
		tgt = t;
		wr(acc_pkg::IDX_CLK_SEL, {6'h00, div});
		wr(acc_pkg::IDX_CONV_CTRL, 8'h20);
		wr(acc_pkg::IDX_CONV_CTRL, 8'ha0);
		rdc("pending after rise", acc_pkg::IDX_CONV_CTRL, 8'ha0 | 8'h40);
		wr(acc_pkg::IDX_CONV_CTRL, 8'h20);
		wr(acc_pkg::IDX_IRQ_CLEAR, 8'h01);
		chk("busy while converting", {31'h0, adc_busy_o}, 32'h1);
		n = 0;
		do begin
			bus(1'b0, acc_pkg::IDX_CONV_CTRL, 8'h00, 4'hf, q);
			n++;
		end while (q[6] !== 1'b0 && n < 300);
		chk("pending at end", {24'h0, q}, 32'h20);
		rdc("result high", acc_pkg::IDX_RESULT_HI, t[8:1]);
		rdc("result low", acc_pkg::IDX_RESULT_LO, {t[0], 7'h00});
		rdc("done status", acc_pkg::IDX_IRQ_STATUS, 8'h01);
		chk("busy at end", {31'h0, adc_busy_o}, 32'h0);
		chk("trial code at end", {23'h0, dac_code_o}, {23'h0, t});
		$display("test conversion div %0d done", div);
	endtask

	initial begin
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'b1000;
		{wb_adr_i, wb_sel_i, wb_dat_i, tgt} = '0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		// reset values of every register
		for (int i = 0; i < 8; i++) rdc("reset value", 6'h20 + 6'(i), 8'h00);
		chk("lines at reset", {28'h0, analog_en_o}, 32'h0);
		$display("test reset done");
		// divider codes and unused bits; the test bit stays clear
		foreach (tgts[i]) begin
			wr(acc_pkg::IDX_CLK_SEL, 8'h7c | 8'(i));
			rdc("clock select", acc_pkg::IDX_CLK_SEL, 8'(i));
		end
		wr(acc_pkg::IDX_CLK_SEL, 8'h00);
		bus(1'b1, acc_pkg::IDX_CLK_SEL, 8'h02, 4'he, q);
		rdc("lane off write", acc_pkg::IDX_CLK_SEL, 8'h00);
		wr(6'h10, 8'hff);
		rdc("unmapped", 6'h10, 8'h00);
		rdc("clear reads zero", acc_pkg::IDX_IRQ_CLEAR, 8'h00);
		$display("test clock select done");
		// every analog config, each with the channel code of the same value
		for (int c = 0; c < 8; c++) begin
			wr(acc_pkg::IDX_CONV_CTRL, {2'b00, 3'(c), 3'(c)});
			chk("lines", {28'h0, analog_en_o}, {28'h0, lines_exp[c]});
			chk("power", {31'h0, adc_power_o}, 32'(c != 0));
			chk("channel", {30'h0, chan_sel_o}, 32'(c % 4));
			rdc("control", acc_pkg::IDX_CONV_CTRL, {2'b00, 3'(c), 3'(c)});
		end
		wr(acc_pkg::IDX_CONV_CTRL, 8'h20);
		chk("all analog ch0", {26'h0, analog_en_o, chan_sel_o}, 32'h3c);
		$display("test config done");
		foreach (tgts[i]) conv(2'(i), tgts[i]);
		chk("masked irq", {31'h0, irq_o}, 32'h0);
		wr(acc_pkg::IDX_IRQ_ENABLE, 8'h01);
		repeat (2) @(posedge clk_i);
		chk("no global", {31'h0, irq_o}, 32'h0);
		wr(acc_pkg::IDX_IRQ_CTRL, 8'h01);
		repeat (2) @(posedge clk_i);
		chk("irq both on", {31'h0, irq_o}, 32'h1);
		tgt = 9'h0aa;
		repeat (40) @(posedge clk_i);
		rdc("held high", acc_pkg::IDX_RESULT_HI, 8'haa);
		rdc("held low", acc_pkg::IDX_RESULT_LO, 8'h80);
		wr(acc_pkg::IDX_IRQ_CLEAR, 8'h01);
		repeat (2) @(posedge clk_i);
		chk("irq cleared", {31'h0, irq_o}, 32'h0);
		rdc("status cleared", acc_pkg::IDX_IRQ_STATUS, 8'h00);
		conv(2'h1, 9'h0aa);
		chk("irq on done", {31'h0, irq_o}, 32'h1);
		$display("test interrupt done");
		test_done();
	end
	// run should end well inside ten thousand cycles
	initial begin
		#100000;
		num_errors++;
		$display("unexpected run time: expected end, seen timeout");
		test_done();
	end
endmodule
`default_nettype wire
